//--- design/mcti_map.svh
`ifndef MCTI_MAP_SVH
`define MCTI_MAP_SVH
// clock and timing
`define MCTI_CLK_NS 5
`define MCTI_GUARD_NS 20000
`define MCTI_GUARD_CYC (`MCTI_GUARD_NS / `MCTI_CLK_NS)
`define MCTI_BAUD_LO 1200
`define MCTI_BAUD_HI 2400
`define MCTI_HALF_LO (1000000000 / (`MCTI_BAUD_LO * 2 * `MCTI_CLK_NS))
`define MCTI_HALF_HI (1000000000 / (`MCTI_BAUD_HI * 2 * `MCTI_CLK_NS))
`define MCTI_CW 17
`define MCTI_GW 12
// data set synchroniser lanes
`define MCTI_I_DTR 0
`define MCTI_I_RTS 1
`define MCTI_I_TXD 2
`define MCTI_I_CH 3
`define MCTI_I_DA 4
`define MCTI_I_DC 5
`define MCTI_NI 6
// terminal synchroniser lanes
`define MCTI_T_RI 0
`define MCTI_T_DCD 1
`define MCTI_T_SQD 2
`define MCTI_T_CI 3
`define MCTI_T_CTS 4
`define MCTI_T_DSR 5
`define MCTI_T_RXD 6
`define MCTI_T_DB 7
`define MCTI_T_DD 8
`define MCTI_NT 9
// terminal register map, byte addresses
`define MCTI_AW 5
`define MCTI_REG_CTRL 5'h00
`define MCTI_REG_STAT 5'h04
`define MCTI_REG_ISTAT 5'h08
`define MCTI_REG_IMASK 5'h0C
`define MCTI_OKAY 2'h0
`define MCTI_SLVERR 2'h2
// control bits
`define MCTI_C_DTR 0
`define MCTI_C_RTS 1
`define MCTI_C_SPD 2
`define MCTI_C_OWNTX 3
`define MCTI_C_OWNRX 4
`define MCTI_NC 5
// event bits
`define MCTI_E_RING 0
`define MCTI_E_DCDOFF 1
`define MCTI_E_SQDOFF 2
`define MCTI_E_CTSON 3
`define MCTI_NE 4
`endif

//--- design/mcti_pkg.sv
`include "mcti_map.svh"
package mcti_pkg;
    typedef enum logic [1:0] {
        MCTI_ON_HOOK = 2'h1,
        MCTI_OFF_HOOK = 2'h2
    } mcti_conn_t;

    typedef struct packed {
        logic [`MCTI_NI-1:0] s1, s2, pv;
        mcti_conn_t conn;
        logic dcd;
        logic [`MCTI_GW-1:0] guard;
        logic ri;
        logic sqd;
        logic cts;
        logic dsr;
        logic ci;
        logic [`MCTI_CW-1:0] tcnt;
        logic db;
        logic [`MCTI_CW-1:0] rcnt;
        logic dd;
        logic rx_prev;
        logic rxd;
        logic txbit;
        logic txen;
        logic txout;
    } mcti_dce_st_t;

    typedef struct packed {
        logic [`MCTI_NT-1:0] s1, s2, pv;
        logic [`MCTI_NC-1:0] ctrl;
        logic [`MCTI_NE-1:0] istat;
        logic [`MCTI_NE-1:0] imask;
        logic irq;
        logic aw_got;
        logic [`MCTI_AW-1:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic txd;
        logic take;
        logic rxb;
        logic rxv;
        logic [`MCTI_CW-1:0] acnt;
        logic da;
        logic [`MCTI_CW-1:0] ccnt;
        logic dc;
    } mcti_dte_st_t;
endpackage

//--- design/mcti_if.sv
`timescale 1ns/1ps
interface mcti_if;
    // terminal to data set
    logic dtr;
    logic rts;
    logic txd;
    logic ch;
    logic da;
    logic dc;
    // data set to terminal
    logic ri;
    logic dcd;
    logic sqd;
    logic ci;
    logic cts;
    logic dsr;
    logic rxd;
    logic db;
    logic dd;

    modport dce (
        input dtr, rts, txd, ch, da, dc,
        output ri, dcd, sqd, ci, cts, dsr, rxd, db, dd
    );
    modport dte (
        output dtr, rts, txd, ch, da, dc,
        input ri, dcd, sqd, ci, cts, dsr, rxd, db, dd
    );
endinterface

//--- design/mcti_dte.sv
`timescale 1ns/1ps
`include "mcti_map.svh"
module mcti_dte #(
    parameter logic [`MCTI_CW-1:0] HALF_LO = `MCTI_CW'(`MCTI_HALF_LO),
    parameter logic [`MCTI_CW-1:0] HALF_HI = `MCTI_CW'(`MCTI_HALF_HI)
) (
    input wire logic mclk,
    input wire logic resetn,
    mcti_if.dte link,
    input wire logic [`MCTI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`MCTI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    input wire logic tx_bit,
    output logic tx_bit_take,
    output logic rx_bit,
    output logic rx_bit_valid
);
    mcti_pkg::mcti_dte_st_t st, next_st;
    logic [`MCTI_NE-1:0] ev, clr;
    logic [`MCTI_CW-1:0] half;
    logic tx_step, rx_step, send_ok;

    // word decode shared by both channels
    function automatic logic mapped(logic [`MCTI_AW-1:0] a);
        logic [`MCTI_AW-1:0] w;
        w = {a[`MCTI_AW-1:2], 2'h0};
        mapped = (w == `MCTI_REG_CTRL) || (w == `MCTI_REG_STAT) ||
            (w == `MCTI_REG_ISTAT) || (w == `MCTI_REG_IMASK);
    endfunction

    // handshakes held off while an answer is pending
    assign awready = ~st.aw_got & ~st.bvalid;
    assign wready = ~st.w_got & ~st.bvalid;
    assign arready = ~st.rvalid;
    assign half = (st.ctrl[`MCTI_C_SPD] | st.s2[`MCTI_T_CI]) ?
        HALF_HI - 1'b1 : HALF_LO - 1'b1;
    assign send_ok = st.ctrl[`MCTI_C_RTS] & st.s2[`MCTI_T_CTS] &
        st.s2[`MCTI_T_DSR];

    always_comb begin
        next_st = st;
        ev = '0;
        clr = '0;
        next_st.s1 = {link.dd, link.db, link.rxd, link.dsr, link.cts,
            link.ci, link.sqd, link.dcd, link.ri};
        next_st.s2 = st.s1;
        next_st.pv = st.s2;
        // register bus
        if (awvalid & awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = awaddr;
        end
        if (wvalid & wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = wdata;
            next_st.wstrb0 = wstrb[0];
        end
        if (st.bvalid & bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_got & st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = mapped(st.awaddr) ? `MCTI_OKAY : `MCTI_SLVERR;
            if (st.wstrb0) begin
                unique case ({st.awaddr[`MCTI_AW-1:2], 2'h0})
                    `MCTI_REG_CTRL: next_st.ctrl = st.wdata[`MCTI_NC-1:0];
                    `MCTI_REG_ISTAT: clr = st.wdata[`MCTI_NE-1:0];
                    `MCTI_REG_IMASK: next_st.imask = st.wdata[`MCTI_NE-1:0];
                    default: ;
                endcase
            end
        end
        if (st.rvalid & rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid & arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = mapped(araddr) ? `MCTI_OKAY : `MCTI_SLVERR;
            next_st.rdata = '0;
            unique case ({araddr[`MCTI_AW-1:2], 2'h0})
                `MCTI_REG_CTRL: next_st.rdata[`MCTI_NC-1:0] = st.ctrl;
                `MCTI_REG_STAT: next_st.rdata[5:0] = st.s2[5:0];
                `MCTI_REG_ISTAT: next_st.rdata[`MCTI_NE-1:0] = st.istat;
                `MCTI_REG_IMASK: next_st.rdata[`MCTI_NE-1:0] = st.imask;
                default: ;
            endcase
        end
        // sticky events, a new event beats the clear
        ev[`MCTI_E_RING] = st.s2[`MCTI_T_RI] & ~st.pv[`MCTI_T_RI];
        ev[`MCTI_E_DCDOFF] = st.pv[`MCTI_T_DCD] & ~st.s2[`MCTI_T_DCD];
        ev[`MCTI_E_SQDOFF] = st.pv[`MCTI_T_SQD] & ~st.s2[`MCTI_T_SQD];
        ev[`MCTI_E_CTSON] = st.s2[`MCTI_T_CTS] & ~st.pv[`MCTI_T_CTS];
        next_st.istat = (st.istat & ~clr) | ev;
        next_st.irq = |(next_st.istat & next_st.imask);
        // own transmit timing, data changes on its rise
        if (!st.ctrl[`MCTI_C_OWNTX]) begin
            next_st.acnt = '0;
            next_st.da = 1'b0;
        end else if (st.acnt == '0) begin
            next_st.acnt = half;
            next_st.da = ~st.da;
        end else begin
            next_st.acnt = st.acnt - 1'b1;
        end
        tx_step = st.ctrl[`MCTI_C_OWNTX] ?
            (st.acnt == '0) & ~st.da :
            st.s2[`MCTI_T_DB] & ~st.pv[`MCTI_T_DB];
        next_st.take = 1'b0;
        if (tx_step) begin
            next_st.txd = send_ok ? tx_bit : 1'b1;
            next_st.take = send_ok;
        end
        // own receive timing, sample on its fall
        if (!st.ctrl[`MCTI_C_OWNRX]) begin
            next_st.ccnt = '0;
            next_st.dc = 1'b0;
        end else if (st.ccnt == '0) begin
            next_st.ccnt = half;
            next_st.dc = ~st.dc;
        end else begin
            next_st.ccnt = st.ccnt - 1'b1;
        end
        rx_step = st.ctrl[`MCTI_C_OWNRX] ?
            (st.ccnt == '0) & st.dc :
            st.pv[`MCTI_T_DD] & ~st.s2[`MCTI_T_DD];
        next_st.rxv = rx_step & st.s2[`MCTI_T_DCD];
        if (rx_step) begin
            next_st.rxb = st.s2[`MCTI_T_RXD];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '{txd: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign link.dtr = st.ctrl[`MCTI_C_DTR];
    assign link.rts = st.ctrl[`MCTI_C_RTS];
    assign link.ch = st.ctrl[`MCTI_C_SPD];
    assign link.txd = st.txd;
    assign link.da = st.da;
    assign link.dc = st.dc;
    assign bresp = st.bresp;
    assign bvalid = st.bvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign rvalid = st.rvalid;
    assign irq = st.irq;
    assign tx_bit_take = st.take;
    assign rx_bit = st.rxb;
    assign rx_bit_valid = st.rxv;
endmodule

//--- design/mcti_dce.sv
`timescale 1ns/1ps
`include "mcti_map.svh"
// What this block does
// - terminal ready on connects the converter
// - originate-only: connect and hold need ext_conn as well as terminal ready
// - auto answer: connect on ring with ready
// - terminal ready off disconnects the converter
// - ring indicator works while ready is off
// - ring indicator on only during ringing
// - carrier detect drops after guard time
// - half duplex local copy: local carrier also counts
// - quality detect off before next element
// - terminal may retransmit on quality loss
// - terminal speed select picks higher rate
// - data set speed select picks higher rate
// - terminal tx timing falls mid-element
// - tx timing square; terminal changes on rise
// - terminal rx timing falls mid-element
// - rx timing square, falls mid-element
// - mark is one and idle
// - transmit only with request, clear, ready
module mcti_dce #(
    parameter logic [`MCTI_CW-1:0] HALF_LO = `MCTI_CW'(`MCTI_HALF_LO),
    parameter logic [`MCTI_CW-1:0] HALF_HI = `MCTI_CW'(`MCTI_HALF_HI)
) (
    input wire logic mclk,
    input wire logic resetn,
    mcti_if.dce link,
    input wire logic line_ring,
    input wire logic line_carrier,
    input wire logic line_quality_ok,
    input wire logic line_rx_bit,
    input wire logic ext_conn,
    input wire logic auto_answer,
    input wire logic orig_only,
    input wire logic half_duplex,
    input wire logic local_copy,
    input wire logic own_speed_hi,
    input wire logic ext_tx_timing,
    input wire logic ext_rx_timing,
    output logic line_connect,
    output logic line_tx_en,
    output logic line_tx_bit
);
    localparam logic [`MCTI_GW-1:0] GUARD =
        `MCTI_GW'(`MCTI_GUARD_CYC - 1);

    mcti_pkg::mcti_dce_st_t st, next_st;
    logic dtr, rts, off_hook, conn_req, sel_hi, carrier_eff;
    logic tx_centre, rx_edge, rx_start, rx_load, rx_src;
    logic [`MCTI_CW-1:0] half;

    // reload value of a half element, used by both dividers
    function automatic logic [`MCTI_CW-1:0] half_of(logic hi);
        half_of = hi ? HALF_HI - 1'b1 : HALF_LO - 1'b1;
    endfunction

    // only second-stage copies and the edge stage behind them are read
    assign dtr = st.s2[`MCTI_I_DTR];
    assign rts = st.s2[`MCTI_I_RTS];
    assign off_hook = (st.conn == mcti_pkg::MCTI_OFF_HOOK);
    // either side may ask for the higher rate
    assign sel_hi = st.s2[`MCTI_I_CH] | own_speed_hi;
    assign half = half_of(sel_hi);

    // what may take the line off hook
    always_comb begin
        if (orig_only) begin
            conn_req = ext_conn;
        end else if (auto_answer) begin
            conn_req = line_ring;
        end else begin
            conn_req = 1'b1;
        end
    end

    // local carrier counts only when our own output is copied back
    assign carrier_eff = line_carrier |
        (half_duplex & local_copy & st.txen);

    // element edges on each side
    assign tx_centre = ext_tx_timing ?
        st.pv[`MCTI_I_DA] & ~st.s2[`MCTI_I_DA] :
        (st.tcnt == '0) & st.db;
    assign rx_edge = (line_rx_bit != st.rx_prev);
    assign rx_start = rx_edge | ((st.rcnt == '0) & ~st.dd);
    assign rx_load = ext_rx_timing ?
        st.s2[`MCTI_I_DC] & ~st.pv[`MCTI_I_DC] : rx_start;
    // half duplex while sending: copy back or hold mark
    assign rx_src = (half_duplex & st.txen) ?
        (local_copy ? st.s2[`MCTI_I_TXD] : 1'b1) : line_rx_bit;

    always_comb begin
        next_st = st;
        // two-stage synchroniser, then one more for edges
        next_st.s1 = {link.dc, link.da, link.ch, link.txd,
            link.rts, link.dtr};
        next_st.s2 = st.s1;
        next_st.pv = st.s2;

        // line connection
        unique case (st.conn)
            mcti_pkg::MCTI_ON_HOOK: begin
                if (dtr & conn_req) begin
                    next_st.conn = mcti_pkg::MCTI_OFF_HOOK;
                end
            end
            mcti_pkg::MCTI_OFF_HOOK: begin
                if (!dtr) begin
                    next_st.conn = mcti_pkg::MCTI_ON_HOOK;
                end else if (orig_only & ~ext_conn) begin
                    next_st.conn = mcti_pkg::MCTI_ON_HOOK;
                end
            end
        endcase

        // ring indication ignores terminal ready
        next_st.ri = line_ring;

        // carrier detect with guard-time drop
        if (carrier_eff) begin
            next_st.dcd = 1'b1;
            next_st.guard = GUARD;
        end else if (st.dcd) begin
            if (st.guard == '0) begin
                next_st.dcd = 1'b0;
            end else begin
                next_st.guard = st.guard - 1'b1;
            end
        end

        // one cycle is far shorter than any element
        next_st.sqd = line_carrier & line_quality_ok;
        next_st.ci = own_speed_hi;

        // ready and clear follow the connection at once
        next_st.dsr = off_hook;
        next_st.cts = rts & off_hook;
        next_st.txen = rts & st.cts & st.dsr;

        // transmit element timing, a new rate starts at the next half
        if (st.tcnt == '0) begin
            next_st.tcnt = half;
            next_st.db = ~st.db;
        end else begin
            next_st.tcnt = st.tcnt - 1'b1;
        end
        // sample terminal data mid-element
        if (tx_centre) begin
            next_st.txbit = st.s2[`MCTI_I_TXD];
        end
        next_st.txout = st.txen ? st.txbit : 1'b1;

        // receive timing realigns on every data edge
        next_st.rx_prev = line_rx_bit;
        if (rx_edge) begin
            next_st.rcnt = half;
            next_st.dd = 1'b1;
        end else if (st.rcnt == '0) begin
            next_st.rcnt = half;
            next_st.dd = ~st.dd;
        end else begin
            next_st.rcnt = st.rcnt - 1'b1;
        end
        // idle mark while on hook
        if (!off_hook) begin
            next_st.rxd = 1'b1;
        end else if (rx_load) begin
            next_st.rxd = rx_src;
        end
    end

    // the whole state in one register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '{conn: mcti_pkg::MCTI_ON_HOOK, rxd: 1'b1, txbit: 1'b1,
                txout: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign link.ri = st.ri;
    assign link.dcd = st.dcd;
    assign link.sqd = st.sqd;
    assign link.ci = st.ci;
    assign link.cts = st.cts;
    assign link.dsr = st.dsr;
    assign link.rxd = st.rxd;
    assign link.db = st.db;
    assign link.dd = st.dd;
    assign line_connect = off_hook;
    assign line_tx_en = st.txen;
    assign line_tx_bit = st.txout;
endmodule

//--- tb/mcti_asserts.sv
`timescale 1ns/1ps
`include "mcti_map.svh"
module mcti_asserts #(
    parameter logic [`MCTI_CW-1:0] HALF_LO = 17'h00008,
    parameter logic [`MCTI_CW-1:0] HALF_HI = 17'h00004
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic dtr,
    input wire logic rts,
    input wire logic txd,
    input wire logic da,
    input wire logic cts,
    input wire logic dsr,
    input wire logic dcd,
    input wire logic sqd,
    input wire logic rxd,
    input wire logic db,
    input wire logic dd
);
    logic db_q, dd_q, da_q, seen;
    logic [17:0] db_cnt, dd_cnt;
    logic [3:0] step;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // half counters; step saturates so a stale count never wraps
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            db_q <= 1'b0;
            dd_q <= 1'b0;
            da_q <= 1'b0;
            seen <= 1'b0;
            db_cnt <= 18'h00000;
            dd_cnt <= 18'h00000;
            step <= 4'hF;
        end else begin
            db_q <= db;
            dd_q <= dd;
            da_q <= da;
            seen <= seen | (db != db_q);
            db_cnt <= (db != db_q) ? 18'h00001 : db_cnt + 18'h00001;
            dd_cnt <= (dd != dd_q) ? 18'h00001 : dd_cnt + 18'h00001;
            step <= ((db && !db_q) || (da && !da_q)) ? 4'h0 :
                step + {3'h0, step != 4'hF};
        end
    end

    dtr_drop_a: assert property ($fell(dtr) |-> ##[1:8] !dsr)
        else $error("dsr held after dtr off");
    onhook_idle_a: assert property (!dtr [*8] |-> !dsr && !cts)
        else $error("ready or clear while dtr off");
    cts_rts_a: assert property (!rts [*6] |-> !cts)
        else $error("cts without rts");
    cts_dsr_a: assert property (cts |-> dsr)
        else $error("cts without dsr");
    dtr_sync_a: assert property ($rose(dsr) |-> $past(dtr, 3))
        else $error("dsr rose too soon after dtr");
    sqd_dcd_a: assert property (sqd |-> dcd)
        else $error("sqd on without dcd");
    db_half_a: assert property (seen && db != db_q |->
        db_cnt == 18'(HALF_LO) || db_cnt == 18'(HALF_HI))
        else $error("db half period wrong");
    dd_half_a: assert property (dd_cnt <= 18'(HALF_LO) * 18'h2 + 18'h2)
        else $error("dd stuck");
    // on own timing txd moves on the same edge as the da rise
    tx_step_a: assert property ($changed(txd) |->
        step <= 4'h8 || (da && !da_q))
        else $error("txd moved away from a timing rise");
    rx_mark_a: assert property (!dsr [*8] |-> rxd)
        else $error("rxd not marking on hook");
endmodule

//--- tb/modem_control_timing_interface_tb_top.sv
`timescale 1ns/1ps
`include "mcti_map.svh"
module modem_control_timing_interface_tb_top;
    localparam logic [16:0] half_lo = 17'h00010;
    localparam logic [16:0] half_hi = 17'h00008;
    localparam logic [11:0] rx_word = 12'hF2D;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, tx_bit = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic tx_bit_take, rx_bit, rx_bit_valid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic line_ring = 1'b0, line_carrier = 1'b0, line_quality_ok = 1'b0;
    logic line_rx_bit = 1'b1, ext_conn = 1'b0, auto_answer = 1'b0;
    logic orig_only = 1'b0, half_duplex = 1'b0, local_copy = 1'b0;
    logic own_speed_hi = 1'b0;
    logic ext_tx_timing = 1'b0, ext_rx_timing = 1'b0, rerun = 1'b0;
    logic line_connect, line_tx_en, line_tx_bit;
    logic [31:0] tx_pat = {8'h2D, 24'hFFFFFF};
    logic [11:0] txs = 12'h000, rxs = 12'h000;
    logic tx_hit = 1'b0, rx_hit = 1'b0, db_q = 1'b0;
    int n_errors = 0;
    int samples_checked = 0;

    mcti_if link();
    mcti_dte #(.HALF_LO(half_lo), .HALF_HI(half_hi)) mcti_dte_i (
        .mclk(mclk), .resetn(resetn), .link(link), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq),
        .tx_bit(tx_bit), .tx_bit_take(tx_bit_take), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid));
    mcti_dce #(.HALF_LO(half_lo), .HALF_HI(half_hi)) mcti_dce_i (
        .mclk(mclk), .resetn(resetn), .link(link), .line_ring(line_ring),
        .line_carrier(line_carrier), .line_quality_ok(line_quality_ok),
        .line_rx_bit(line_rx_bit), .ext_conn(ext_conn),
        .auto_answer(auto_answer), .orig_only(orig_only),
        .half_duplex(half_duplex), .local_copy(local_copy),
        .own_speed_hi(own_speed_hi), .ext_tx_timing(ext_tx_timing),
        .ext_rx_timing(ext_rx_timing), .line_connect(line_connect),
        .line_tx_en(line_tx_en), .line_tx_bit(line_tx_bit));
    mcti_asserts #(.HALF_LO(half_lo), .HALF_HI(half_hi)) mcti_asserts_i (
        .mclk(mclk), .resetn(resetn), .dtr(link.dtr), .rts(link.rts),
        .txd(link.txd), .da(link.da), .cts(link.cts), .dsr(link.dsr),
        .dcd(link.dcd), .sqd(link.sqd), .rxd(link.rxd), .db(link.db),
        .dd(link.dd));

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // line taps; marks on both sides make the pattern unambiguous
    always @(posedge mclk) begin
        db_q <= link.db;
        if (link.db && !db_q) txs <= {txs[10:0], line_tx_bit};
        if (rx_bit_valid === 1'b1) rxs <= {rxs[10:0], rx_bit};
        if (txs == rx_word) tx_hit <= 1'b1;
        if (rxs == rx_word) rx_hit <= 1'b1;
        // a rerun rearms the pattern and the hit flags for another pass
        if (rerun) begin
            tx_hit <= 1'b0;
            rx_hit <= 1'b0;
            tx_bit <= 1'b0;
            tx_pat <= {8'h2D, 24'hFFFFFF};
        end else if (tx_bit_take === 1'b1) begin
            tx_bit <= tx_pat[30];
            tx_pat <= {tx_pat[30:0], 1'b1};
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // each channel released at its own handshake edge
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
        input logic [1:0] e);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                done = 1'b1;
                chk(32'(bresp), 32'(e));
            end
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] x,
        input logic [1:0] e);
        logic done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                done = 1'b1;
                chk(rdata, x);
                chk(32'(rresp), 32'(e));
            end
        end
    endtask

    // settle first: a new speed only applies from the next half
    task automatic half(input logic [16:0] exp);
        logic v;
        int n;
        n = 0;
        cyc(64);
        v = link.db;
        while (link.db === v) @(posedge mclk);
        v = link.db;
        while (link.db === v) begin
            @(posedge mclk);
            n++;
        end
        chk(32'(n), 32'(exp));
    endtask

    // bounded so a hang still reaches the verdict
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        results();
    end

    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rd(`MCTI_REG_CTRL, 32'h00000000, `MCTI_OKAY);
        rd(`MCTI_REG_STAT, 32'h00000000, `MCTI_OKAY);
        rd(5'h10, 32'h00000000, `MCTI_SLVERR);
        wr(5'h14, 32'h0000000F, `MCTI_SLVERR);
        auto_answer <= 1'b1;
        line_ring <= 1'b1;
        cyc(10);
        chk(32'(link.ri), 32'h1);
        chk(32'(line_connect), 32'h0);
        rd(`MCTI_REG_STAT, 32'h00000001, `MCTI_OKAY);
        wr(`MCTI_REG_IMASK, 32'h00000001, `MCTI_OKAY);
        cyc(3);
        chk(32'(irq), 32'h1);
        line_ring <= 1'b0;
        cyc(10);
        chk(32'(link.ri), 32'h0);
        wr(`MCTI_REG_ISTAT, 32'h00000001, `MCTI_OKAY);
        cyc(3);
        chk(32'(irq), 32'h0);
        wr(`MCTI_REG_CTRL, 32'h00000001, `MCTI_OKAY);
        cyc(10);
        chk(32'(line_connect), 32'h0);
        line_ring <= 1'b1;
        cyc(10);
        chk(32'(line_connect), 32'h1);
        line_ring <= 1'b0;
        auto_answer <= 1'b0;
        cyc(10);
        chk(32'(link.dsr), 32'h1);
        chk({30'h0, line_tx_en, line_tx_bit}, 32'h1);
        wr(`MCTI_REG_CTRL, 32'h00000000, `MCTI_OKAY);
        cyc(10);
        chk({30'h0, line_connect, link.dsr}, 32'h0);
        orig_only <= 1'b1;
        wr(`MCTI_REG_CTRL, 32'h00000001, `MCTI_OKAY);
        cyc(10);
        chk(32'(line_connect), 32'h0);
        ext_conn <= 1'b1;
        cyc(10);
        chk(32'(line_connect), 32'h1);
        ext_conn <= 1'b0;
        cyc(10);
        chk(32'(line_connect), 32'h0);
        orig_only <= 1'b0;
        half(half_lo);
        wr(`MCTI_REG_CTRL, 32'h00000005, `MCTI_OKAY);
        half(half_hi);
        wr(`MCTI_REG_CTRL, 32'h00000001, `MCTI_OKAY);
        own_speed_hi <= 1'b1;
        half(half_hi);
        chk(32'(link.ci), 32'h1);
        own_speed_hi <= 1'b0;
        half(half_lo);
        line_carrier <= 1'b1;
        line_quality_ok <= 1'b1;
        wr(`MCTI_REG_CTRL, 32'h00000003, `MCTI_OKAY);
        cyc(10);
        wr(`MCTI_REG_ISTAT, 32'h0000000F, `MCTI_OKAY);
        chk({28'h0, link.cts, link.dsr, link.dcd, link.sqd}, 32'hF);
        for (int i = 11; i >= 0; i--) begin
            line_rx_bit <= rx_word[i];
            repeat (2 * half_lo) @(posedge mclk);
        end
        cyc(8 * half_lo);
        chk({30'h0, tx_hit, rx_hit}, 32'h3);
        // same transfer on the terminal's own element timing
        ext_tx_timing <= 1'b1;
        ext_rx_timing <= 1'b1;
        wr(`MCTI_REG_CTRL, 32'h0000001B, `MCTI_OKAY);
        rerun <= 1'b1;
        cyc(1);
        rerun <= 1'b0;
        for (int i = 11; i >= 0; i--) begin
            line_rx_bit <= rx_word[i];
            repeat (2 * half_lo) @(posedge mclk);
        end
        cyc(8 * half_lo);
        chk({30'h0, tx_hit, rx_hit}, 32'h3);
        line_quality_ok <= 1'b0;
        cyc(half_lo);
        chk(32'(link.sqd), 32'h0);
        rd(`MCTI_REG_ISTAT, 32'h00000004, `MCTI_OKAY);
        wr(`MCTI_REG_IMASK, 32'h00000004, `MCTI_OKAY);
        cyc(3);
        chk(32'(irq), 32'h1);
        wr(`MCTI_REG_IMASK, 32'h00000000, `MCTI_OKAY);
        cyc(3);
        chk(32'(irq), 32'h0);
        line_carrier <= 1'b0;
        cyc(`MCTI_GUARD_CYC - 100);
        chk(32'(link.dcd), 32'h1);
        cyc(200);
        chk(32'(link.dcd), 32'h0);
        half_duplex <= 1'b1;
        local_copy <= 1'b1;
        cyc(10);
        chk(32'(link.dcd), 32'h1);
        results();
    end
endmodule
